// File: hw/fam_map.svh
// Purpose: offsets, field positions, reset values and timing counts of the flash map block
// Assumes: byte-wide register port, 16-bit program memory address
// Notes:   definitions only
`ifndef FAM_MAP_SVH
`define FAM_MAP_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define FAM_OFS_CMD        2'h0
`define FAM_OFS_PAGE       2'h1
`define FAM_OFS_FREQ_HI    2'h2
`define FAM_OFS_FREQ_LO    2'h3

// ----------------------------------------------------------------
// command codes
// ----------------------------------------------------------------
`define FAM_CMD_RESET      8'h00
`define FAM_CMD_UNLOCK1    8'h73
`define FAM_CMD_UNLOCK2    8'h8c
`define FAM_CMD_PROT_SEL   8'h5e
`define FAM_CMD_PAGE_ERASE 8'h95
`define FAM_CMD_MASS_ERASE 8'h63

// ----------------------------------------------------------------
// fields and layout
// ----------------------------------------------------------------
`define FAM_PAGE_INFO_BIT  7
`define FAM_PAGE_LSB       9
`define FAM_INFO_BASE      16'hfe00
`define FAM_ID_FIRST       16'hfe40
`define FAM_ID_LAST        16'hfe53
`define FAM_ID_CHARS       20
`define FAM_ST_UNLOCKED    0
`define FAM_ST_PROT_SEL    1
`define FAM_ST_BUSY        2
`define FAM_ST_REFUSED     3
`define FAM_RESET_BYTE     8'h00
`define FAM_ERASED_BYTE    8'hff

// ----------------------------------------------------------------
// timing: one tick is 10 us, derived from the kHz value
// ----------------------------------------------------------------
`define FAM_TICK_US        10
`define FAM_TICK_DIV       (1000 / `FAM_TICK_US)
`define FAM_PROG_TIME_US   40
`define FAM_PROG_TICKS     (`FAM_PROG_TIME_US / `FAM_TICK_US)
`define FAM_PERASE_TIME_MS 10
`define FAM_MERASE_TIME_MS 200

`endif

// File: hw/fam_pkg.sv
// Purpose: types shared by the flash map block and its bench
// Assumes: fam_map.svh holds the numbers
// Notes:   none
package fam_pkg;

  typedef enum logic [2:0] {
    FAM_LK_LOCKED,
    FAM_LK_CLEARED,
    FAM_LK_PAGE,
    FAM_LK_KEY1,
    FAM_LK_KEY2,
    FAM_LK_OPEN
  } fam_lock_t;

  typedef enum logic [1:0] {
    FAM_OP_NONE,
    FAM_OP_PROG,
    FAM_OP_PERASE,
    FAM_OP_MERASE
  } fam_op_t;

  // program memory request from core or debugger
  typedef struct packed {
    logic        rd;
    logic        fetch;
    logic        wr;
    logic        dbg;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } fam_mem_req_t;

  // drive to the flash array macro
  typedef struct packed {
    logic        prog;
    logic        page_erase;
    logic        mass_erase;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } fam_array_t;

  typedef struct packed {
    fam_lock_t   lock;
    logic        lock_dbg;
    fam_op_t     op;
    logic [7:0]  page_sel;
    logic [7:0]  protect;
    logic        prot_sel;
    logic [15:0] freq;
    logic        refused;
    logic [15:0] div_cnt;
    logic [14:0] ticks;
    logic [15:0] op_addr;
    logic [7:0]  op_data;
    logic [7:0]  reg_rdata;
    logic [7:0]  mem_rdata;
    logic [1:0]  bypass_sync;
  } fam_state_t;

endpackage

// File: hw/fam_ctrl.sv
// Purpose: flash page/sector map, information overlay, unlock guard and program/erase timing
// Assumes: array reads answer combinationally on array_o.addr; option bits on the same clock
// Notes:   core stalls on busy_o while a program or erase runs
//
// The register offsets and strobed register access are this design's own decisions.
`include "fam_map.svh"
`timescale 1ns/1ps
`default_nettype none

module fam_ctrl
  import fam_pkg::*;
#(
  parameter int unsigned SECTOR_SHIFT  = 13,
  parameter int unsigned PERASE_TICKS  = (`FAM_PERASE_TIME_MS * 1000) / `FAM_TICK_US,
  parameter int unsigned MERASE_TICKS  = (`FAM_MERASE_TIME_MS * 1000) / `FAM_TICK_US,
  parameter logic [159:0] PART_ID      = {"FLASHMAP-DEMO", 56'h0}  // arbitrary value
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         reset_i,
  // register port
  input  wire logic [1:0]   reg_addr_i,
  input  wire logic [7:0]   reg_wdata_i,
  input  wire logic         reg_we_i,
  input  wire logic         reg_re_i,
  input  wire logic         reg_dbg_i,
  output logic      [7:0]   reg_rdata_o,
  // program memory port
  input  wire fam_mem_req_t mem_req_i,
  output logic      [7:0]   mem_rdata_o,
  output logic              busy_o,
  // option bits and bypass pin
  input  wire logic         read_protect_i,
  input  wire logic         write_protect_i,
  input  wire logic         bypass_pin_i,
  output logic              bypass_read_ok_o,
  // flash array
  output fam_array_t        array_o,
  input  wire logic [7:0]   array_rdata_i
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [2:0] sector_of(input logic [15:0] a);
    logic [15:0] s;
    s = a >> SECTOR_SHIFT;
    return s[2:0];
  endfunction

  function automatic logic in_info(input logic [15:0] a);
    return a[15:`FAM_PAGE_LSB] == 7'(`FAM_INFO_BASE >> `FAM_PAGE_LSB);
  endfunction

  function automatic logic [7:0] info_byte(input logic [15:0] a);
    logic [15:0] idx;
    idx = a - `FAM_ID_FIRST;
    info_byte = 8'h00;
    if (a >= `FAM_ID_FIRST && a <= `FAM_ID_LAST) begin
      info_byte = PART_ID[159 - 8 * idx[4:0] -: 8];
    end
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  fam_state_t q;
  fam_state_t next_q;

  logic        info_en;
  logic        bypass_on;
  logic        dbg_blocked;
  logic        guard_ok;
  logic        mem_in_page;
  logic [15:0] tick_period;
  logic [15:0] freq_div;

  assign info_en     = q.page_sel[`FAM_PAGE_INFO_BIT];
  assign bypass_on   = q.bypass_sync[1];
  assign dbg_blocked = read_protect_i && (mem_req_i.dbg || bypass_on);
  assign mem_in_page = mem_req_i.addr[15:`FAM_PAGE_LSB] == q.page_sel[6:0];
  assign freq_div    = q.freq / 16'(`FAM_TICK_DIV);
  assign tick_period = (freq_div == 16'h0) ? 16'h1 : freq_div;

  // debugger ignores sector protect and the write-protect option
  assign guard_ok = mem_req_i.dbg ||
                    (!q.protect[sector_of(mem_req_i.addr)] && !write_protect_i);

  always_comb begin
    next_q             = q;
    next_q.bypass_sync = {q.bypass_sync[0], bypass_pin_i};
    next_q.reg_rdata   = 8'h00;

    // ----------------------------------------------------------------
    // register reads
    // ----------------------------------------------------------------
    if (reg_re_i) begin
      case (reg_addr_i)
        `FAM_OFS_CMD: begin
          next_q.reg_rdata[`FAM_ST_UNLOCKED] = q.lock == FAM_LK_OPEN;
          next_q.reg_rdata[`FAM_ST_PROT_SEL] = q.prot_sel;
          next_q.reg_rdata[`FAM_ST_BUSY]     = q.op != FAM_OP_NONE;
          next_q.reg_rdata[`FAM_ST_REFUSED]  = q.refused;
        end
        `FAM_OFS_PAGE:    next_q.reg_rdata = q.prot_sel ? q.protect : q.page_sel;
        `FAM_OFS_FREQ_HI: next_q.reg_rdata = q.freq[15:8];
        `FAM_OFS_FREQ_LO: next_q.reg_rdata = q.freq[7:0];
        default:          next_q.reg_rdata = 8'h00;
      endcase
    end

    // ----------------------------------------------------------------
    // register writes and unlock sequence
    // ----------------------------------------------------------------
    if (reg_we_i) begin
      case (reg_addr_i)
        `FAM_OFS_CMD: begin
          next_q.prot_sel = reg_wdata_i == `FAM_CMD_PROT_SEL;
          next_q.lock     = FAM_LK_LOCKED;
          if (reg_wdata_i == `FAM_CMD_RESET) begin
            next_q.lock    = FAM_LK_CLEARED;
            next_q.refused = 1'b0;
          end else if (reg_wdata_i == `FAM_CMD_UNLOCK1 && q.lock == FAM_LK_PAGE) begin
            next_q.lock = FAM_LK_KEY1;
          end else if (reg_wdata_i == `FAM_CMD_UNLOCK2 && q.lock == FAM_LK_KEY1) begin
            // debugger skips the page rewrite
            next_q.lock = reg_dbg_i ? FAM_LK_OPEN : FAM_LK_KEY2;
          end else if (reg_wdata_i == `FAM_CMD_PROT_SEL) begin
            next_q.lock = q.lock == FAM_LK_CLEARED ? FAM_LK_CLEARED : FAM_LK_LOCKED;
          end else if (q.lock == FAM_LK_OPEN && q.op == FAM_OP_NONE) begin
            if (reg_wdata_i == `FAM_CMD_PAGE_ERASE) begin
              if (reg_dbg_i || (!q.protect[sector_of({q.page_sel[6:0], 9'h0})]
                                && !write_protect_i)) begin
                next_q.op      = FAM_OP_PERASE;
                next_q.op_addr = {q.page_sel[6:0], 9'h0};
                next_q.ticks   = 15'(PERASE_TICKS);
                next_q.div_cnt = 16'h0;
              end else begin
                next_q.refused = 1'b1;
              end
            end else if (reg_wdata_i == `FAM_CMD_MASS_ERASE && reg_dbg_i) begin
              next_q.op      = FAM_OP_MERASE;
              next_q.ticks   = 15'(MERASE_TICKS);
              next_q.div_cnt = 16'h0;
            end
          end
          next_q.lock_dbg = reg_dbg_i;
        end
        `FAM_OFS_PAGE: begin
          if (q.prot_sel) begin
            // user code can only add protection
            next_q.protect = reg_dbg_i ? reg_wdata_i : (q.protect | reg_wdata_i);
          end else if (q.lock == FAM_LK_OPEN && reg_dbg_i) begin
            next_q.page_sel = reg_wdata_i;
          end else begin
            next_q.page_sel = reg_wdata_i;
            if (q.lock == FAM_LK_CLEARED) begin
              next_q.lock = FAM_LK_PAGE;
            end else if (q.lock == FAM_LK_KEY2 && reg_wdata_i == q.page_sel) begin
              next_q.lock = FAM_LK_OPEN;
            end else begin
              next_q.lock = FAM_LK_LOCKED;
            end
          end
        end
        `FAM_OFS_FREQ_HI: next_q.freq[15:8] = reg_wdata_i;
        `FAM_OFS_FREQ_LO: next_q.freq[7:0]  = reg_wdata_i;
        default: ;
      endcase
    end

    // ----------------------------------------------------------------
    // program memory reads
    // ----------------------------------------------------------------
    if (mem_req_i.rd) begin
      if (dbg_blocked) begin
        next_q.mem_rdata = 8'h00;
      end else if (info_en && !mem_req_i.fetch && in_info(mem_req_i.addr)) begin
        next_q.mem_rdata = info_byte(mem_req_i.addr);
      end else begin
        next_q.mem_rdata = array_rdata_i;
      end
    end

    // ----------------------------------------------------------------
    // byte program
    // ----------------------------------------------------------------
    if (mem_req_i.wr && q.op == FAM_OP_NONE) begin
      if (info_en && in_info(mem_req_i.addr)) begin
        next_q.op = FAM_OP_NONE;
      end else if (q.lock == FAM_LK_OPEN && (mem_in_page || mem_req_i.dbg) && guard_ok) begin
        next_q.op      = FAM_OP_PROG;
        next_q.op_addr = mem_req_i.addr;
        next_q.op_data = mem_req_i.wdata;
        next_q.ticks   = 15'(`FAM_PROG_TICKS);
        next_q.div_cnt = 16'h0;
      end else if (q.lock != FAM_LK_OPEN || !guard_ok) begin
        next_q.refused = 1'b1;
      end
    end

    // ----------------------------------------------------------------
    // operation timing from the kHz value
    // ----------------------------------------------------------------
    if (q.op != FAM_OP_NONE) begin
      if (q.div_cnt >= tick_period - 16'h1) begin
        next_q.div_cnt = 16'h0;
        if (q.ticks <= 15'h1) begin
          next_q.op = FAM_OP_NONE;
          if (q.op != FAM_OP_PROG) begin
            next_q.lock = FAM_LK_LOCKED;
          end
        end else begin
          next_q.ticks = q.ticks - 15'h1;
        end
      end else begin
        next_q.div_cnt = q.div_cnt + 16'h1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      q.lock        <= FAM_LK_LOCKED;
      q.lock_dbg    <= 1'b0;
      q.op          <= FAM_OP_NONE;
      q.page_sel    <= `FAM_RESET_BYTE;
      q.protect     <= `FAM_RESET_BYTE;
      q.prot_sel    <= 1'b0;
      q.freq        <= 16'h0;
      q.refused     <= 1'b0;
      q.div_cnt     <= 16'h0;
      q.ticks       <= 15'h0;
      q.op_addr     <= 16'h0;
      q.op_data     <= `FAM_ERASED_BYTE;
      q.reg_rdata   <= 8'h00;
      q.mem_rdata   <= 8'h00;
      q.bypass_sync <= 2'h0;
    end else begin
      q <= next_q;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign reg_rdata_o         = q.reg_rdata;
  assign mem_rdata_o         = q.mem_rdata;
  assign busy_o              = q.op != FAM_OP_NONE;
  assign bypass_read_ok_o    = bypass_on && !read_protect_i;
  assign array_o.prog        = q.op == FAM_OP_PROG;
  assign array_o.page_erase  = q.op == FAM_OP_PERASE;
  assign array_o.mass_erase  = q.op == FAM_OP_MERASE;
  assign array_o.addr        = (q.op != FAM_OP_NONE) ? q.op_addr : mem_req_i.addr;
  assign array_o.wdata       = q.op_data;

endmodule

`default_nettype wire

// File: verif/fam_array_model.sv
// Purpose: behavioural flash array that sits behind the flash map controller
// Assumes: reads answer combinationally on the address; programming only clears bits
// Notes:   an erase is applied once, at the first cycle of its level
`timescale 1ns/1ps
`default_nettype none

module fam_array_model
  import fam_pkg::*;
(
  // clock
  input  wire logic       clk_i,
  // array side
  input  wire fam_array_t array_i,
  output logic      [7:0] rdata_o
);
  logic [7:0] mem [0:65535];
  logic       erase_q;

  // non-uniform start pattern so a wrong address shows up as wrong data
  initial begin
    for (int a = 0; a < 65536; a++) mem[a] = a[7:0] ^ a[15:8];
    erase_q = 1'b0;
  end

  assign rdata_o = mem[array_i.addr];

  always @(posedge clk_i) begin
    erase_q <= array_i.page_erase | array_i.mass_erase;
    if (array_i.prog) mem[array_i.addr] <= mem[array_i.addr] & array_i.wdata;
    if (array_i.page_erase && !erase_q) begin
      for (int a = 0; a < 512; a++) mem[{array_i.addr[15:9], a[8:0]}] <= 8'hff;
    end
    if (array_i.mass_erase && !erase_q) begin
      for (int a = 0; a < 65536; a++) mem[a] <= 8'hff;
    end
  end
endmodule

`default_nettype wire

// File: verif/fam_ctrl_props.sv
// Purpose: port-level properties of the flash map controller
// Assumes: single clock domain, synchronous active-high reset
// Notes:   bound to every fam_ctrl instance
`timescale 1ns/1ps
`default_nettype none

module fam_ctrl_props
  import fam_pkg::*;
(
  input wire logic         clk_i,
  input wire logic         reset_i,
  input wire logic [1:0]   reg_addr_i,
  input wire logic         reg_we_i,
  input wire logic         reg_re_i,
  input wire logic [7:0]   reg_rdata_o,
  input wire fam_mem_req_t mem_req_i,
  input wire logic [7:0]   mem_rdata_o,
  input wire logic         busy_o,
  input wire logic         read_protect_i,
  input wire logic         write_protect_i,
  input wire logic         bypass_pin_i,
  input wire logic         bypass_read_ok_o,
  input wire fam_array_t   array_o,
  input wire logic [7:0]   array_rdata_i
);
  logic start_q;

  // an operation may only start from a memory write or a command write
  always_ff @(posedge clk_i) begin
    start_q <= mem_req_i.wr | (reg_we_i & (reg_addr_i == 2'h0));
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  sequence s_prog_run;
    array_o.prog ##1 array_o.prog;
  endsequence
  sequence s_dbg_read;
    mem_req_i.rd && mem_req_i.dbg && read_protect_i;
  endsequence
  sequence s_user_wr_wp;
    mem_req_i.wr && !mem_req_i.dbg && write_protect_i && !busy_o;
  endsequence

  chk_rdata_idle: assert property (!reg_re_i |=> reg_rdata_o == 8'h00)
    else $error("register read data not zero outside its cycle");
  chk_busy_cause: assert property ($rose(busy_o) |-> start_q)
    else $error("busy rose without a write or command");
  chk_op_busy: assert property ((array_o.prog || array_o.page_erase) |-> busy_o)
    else $error("array operation without busy");
  chk_op_onehot: assert property ($onehot0({array_o.prog, array_o.page_erase, array_o.mass_erase}))
    else $error("two array operations at once");
  chk_addr_hold: assert property (s_prog_run |-> $stable(array_o.addr))
    else $error("array address moved during programming");
  chk_wp_block: assert property (s_user_wr_wp |=> !array_o.prog)
    else $error("programming started under write protect");
  chk_rp_debug: assert property (s_dbg_read |=> mem_rdata_o == 8'h00)
    else $error("debugger read returned data under read protect");
  chk_fetch_main: assert property (mem_req_i.rd && mem_req_i.fetch && !mem_req_i.dbg && !busy_o
    |=> mem_rdata_o == $past(array_rdata_i))
    else $error("fetch not served from main array");
  chk_rp_bypass: assert property (read_protect_i [*2] |-> !bypass_read_ok_o)
    else $error("bypass read allowed under read protect");
  chk_sync_low: assert property (!bypass_pin_i [*3] |-> !bypass_read_ok_o)
    else $error("bypass read allowed with bypass pin low");
endmodule

bind fam_ctrl fam_ctrl_props u_props (
  .clk_i, .reset_i, .reg_addr_i, .reg_we_i, .reg_re_i, .reg_rdata_o, .mem_req_i, .mem_rdata_o,
  .busy_o, .read_protect_i, .write_protect_i, .bypass_pin_i, .bypass_read_ok_o, .array_o,
  .array_rdata_i
);

`default_nettype wire

// File: verif/tb.sv
// Purpose: self-checking bench of the flash map controller against a reference memory
// Assumes: frequency scaled so one timing tick is TICK cycles
// Notes:   erase lengths shortened through PERASE_TICKS and MERASE_TICKS
`timescale 1ns/1ps
`default_nettype none

module tb
  import fam_pkg::*;
;
  localparam logic [159:0] ID = {"TESTPART-7", 80'h0}; // arbitrary value
  localparam int TICK = 2;
  localparam int PE_TICKS = 3;
  localparam int ME_TICKS = 5;
  localparam logic [15:0] PTS [4] = '{16'h2000, 16'h21ff, 16'h1fff, 16'h2200};

  logic         clk_i, reset_i, reg_we_i, reg_re_i, reg_dbg_i, busy_o;
  logic         read_protect_i, write_protect_i, bypass_pin_i, bypass_read_ok_o;
  logic [1:0]   reg_addr_i;
  logic [7:0]   reg_wdata_i, reg_rdata_o, mem_rdata_o, array_rdata_i;
  fam_mem_req_t mem_req_i;
  fam_array_t   array_o;
  int           err_count, n_checks;
  int           exp_mem [int];
  bit           all_erased;

  fam_ctrl #(.PERASE_TICKS(PE_TICKS), .MERASE_TICKS(ME_TICKS), .PART_ID(ID)) DUT (
    .clk_i, .reset_i, .reg_addr_i, .reg_wdata_i, .reg_we_i, .reg_re_i, .reg_dbg_i, .reg_rdata_o,
    .mem_req_i, .mem_rdata_o, .busy_o, .read_protect_i, .write_protect_i, .bypass_pin_i,
    .bypass_read_ok_o, .array_o, .array_rdata_i
  );
  fam_array_model u_array (.clk_i, .array_i(array_o), .rdata_o(array_rdata_i));

  // ------
  // reference model and bus tasks
  // ------
  function automatic logic [7:0] ref_rd(input int a);
    if (exp_mem.exists(a)) return 8'(exp_mem[a]);
    return all_erased ? 8'hff : 8'(a ^ (a >> 8));
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic reg_wr(input logic [1:0] a, input logic [7:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_we_i <= 1'b1;
    @(posedge clk_i);
    reg_we_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic reg_rd(input logic [1:0] a, output logic [7:0] d);
    reg_addr_i <= a;
    reg_re_i <= 1'b1;
    @(posedge clk_i);
    reg_re_i <= 1'b0;
    #1 d = reg_rdata_o;
    @(posedge clk_i);
  endtask

  task automatic stat(input logic [7:0] m, input logic [7:0] e, input string what);
    logic [7:0] d;
    reg_rd(2'h0, d);
    chk(d & m, e, what);
  endtask

  task automatic wait_idle(output int n);
    n = 0;
    #1;
    while (busy_o !== 1'b0 && n < 5000) begin
      @(posedge clk_i);
      #1 n++;
    end
    if (n >= 5000) chk(8'h01, 8'h00, "busy stuck");
  endtask

  task automatic mem_op(input logic [15:0] a, input logic wr, input logic f, input logic g,
                        input logic [7:0] wd, output logic [7:0] d, output int n);
    mem_req_i <= '{rd: !wr, fetch: f, wr: wr, dbg: g, addr: a, wdata: wd};
    @(posedge clk_i);
    {mem_req_i.rd, mem_req_i.fetch, mem_req_i.wr} <= 3'b000;
    wait_idle(n);
    d = mem_rdata_o;
    @(posedge clk_i);
  endtask

  task automatic ld(input logic [15:0] a, input logic f, input logic g, input logic [7:0] e);
    logic [7:0] r;
    int         n;
    mem_op(a, 1'b0, f, g, 8'h00, r, n);
    chk(r, e, "load data");
  endtask

  task automatic prog(input logic [15:0] a, input logic [7:0] d, input logic ok);
    logic [7:0] r;
    int         n;
    mem_op(a, 1'b1, 1'b0, 1'b0, d, r, n);
    chk(8'(n > 0), 8'(ok), "program start");
    if (ok) begin
      chk(8'(n >= 4 * TICK - 1 && n <= 4 * TICK + 1), 8'h01, "program time");
      exp_mem[a] = ref_rd(a) & d;
    end
    ld(a, 1'b0, 1'b0, ref_rd(a));
  endtask

  task automatic unlock(input logic [7:0] pg);
    reg_wr(2'h0, 8'h00);
    reg_wr(2'h1, pg);
    reg_wr(2'h0, 8'h73);
    reg_wr(2'h0, 8'h8c);
    reg_wr(2'h1, pg);
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ------
  // clock, watchdog, tests
  // ------
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // tests need about 300 cycles; a hundred times that means a hang
  initial begin
    #300000;
    err_count++;
    print_verdict();
  end

  initial begin
    logic [7:0] d, hi, lo;
    int         n;
    {reset_i, reg_we_i, reg_re_i, reg_dbg_i, reg_addr_i, reg_wdata_i} = 14'h2000;
    {read_protect_i, write_protect_i, bypass_pin_i} = 3'b000;
    mem_req_i = '0;
    void'($urandom(32'hf8d0));
    repeat (2) @(posedge clk_i);
    reset_i <= 1'b0;
    stat(8'hff, 8'h00, "status after reset");
    ld(16'hfe40, 1'b0, 1'b0, ref_rd(16'hfe40));
    $display("test reset done");
    hi = 8'($urandom);
    lo = 8'($urandom);
    reg_wr(2'h2, hi);
    reg_wr(2'h3, lo);
    reg_rd(2'h2, d);
    chk(d, hi, "frequency high");
    reg_rd(2'h3, d);
    chk(d, lo, "frequency low");
    // scaled kHz value keeps the run short
    reg_wr(2'h2, 8'h00);
    reg_wr(2'h3, 8'(TICK * 100));
    $display("test frequency done");
    prog(16'h2010, 8'h00, 1'b0);
    stat(8'h08, 8'h08, "refused flag");
    unlock(8'h10);
    stat(8'h0f, 8'h01, "unlocked");
    prog(16'h2000 + 16'($urandom % 512), 8'($urandom), 1'b1);
    prog(16'h2200, 8'h00, 1'b0);
    reg_wr(2'h0, 8'h73);
    stat(8'h01, 8'h00, "relocked");
    unlock(8'h10);
    write_protect_i <= 1'b1;
    prog(16'h2001, 8'h00, 1'b0);
    write_protect_i <= 1'b0;
    $display("test lock done");
    reg_wr(2'h0, 8'h00);
    reg_wr(2'h0, 8'h5e);
    stat(8'h02, 8'h02, "protect selected");
    reg_wr(2'h1, 8'h01);
    reg_wr(2'h1, 8'h00);
    reg_rd(2'h1, d);
    chk(d, 8'h01, "protect bits only set");
    unlock(8'h0f);
    prog(16'h1fff, 8'h00, 1'b0);
    unlock(8'h10);
    prog(16'h2002, 8'h0f, 1'b1);
    $display("test sector done");
    unlock(8'h10);
    reg_wr(2'h0, 8'h95);
    wait_idle(n);
    chk(8'(n >= PE_TICKS * TICK - 2 && n <= PE_TICKS * TICK + 1), 8'h01, "erase time");
    for (int i = 0; i < 512; i++) exp_mem[16'h2000 + i] = 255;
    foreach (PTS[i]) ld(PTS[i], 1'b0, 1'b0, ref_rd(PTS[i]));
    stat(8'h01, 8'h00, "locked after erase");
    $display("test erase done");
    reg_wr(2'h1, 8'h80);
    for (int k = 0; k < 20; k++) ld(16'hfe40 + 16'(k), 1'b0, 1'b0, ID[159 - 8 * k -: 8]);
    ld(16'hfdff, 1'b0, 1'b0, ref_rd(16'hfdff));
    ld(16'hfe40, 1'b1, 1'b0, ref_rd(16'hfe40));
    unlock(8'hff);
    mem_op(16'hfe45, 1'b1, 1'b0, 1'b0, 8'h00, d, n);
    chk(8'(n), 8'h00, "information write");
    ld(16'hfe45, 1'b0, 1'b0, ID[119 -: 8]);
    reg_wr(2'h1, 8'h00);
    ld(16'hfe45, 1'b0, 1'b0, ref_rd(16'hfe45));
    $display("test information done");
    read_protect_i <= 1'b1;
    ld(16'h2100, 1'b0, 1'b1, 8'h00);
    ld(16'h2100, 1'b0, 1'b0, ref_rd(16'h2100));
    bypass_pin_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    #1 chk(8'(bypass_read_ok_o), 8'h00, "bypass blocked");
    @(posedge clk_i);
    read_protect_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    #1 chk(8'(bypass_read_ok_o), 8'h01, "bypass open");
    @(posedge clk_i);
    bypass_pin_i <= 1'b0;
    $display("test protect done");
    // debugger: 8C opens without the page rewrite, then mass erase
    reg_dbg_i <= 1'b1;
    reg_wr(2'h0, 8'h00);
    reg_wr(2'h1, 8'h04);
    reg_wr(2'h0, 8'h73);
    reg_wr(2'h0, 8'h8c);
    stat(8'h01, 8'h01, "debugger unlocked");
    reg_wr(2'h0, 8'h63);
    wait_idle(n);
    chk(8'(n >= ME_TICKS * TICK - 2 && n <= ME_TICKS * TICK + 1), 8'h01, "mass erase");
    reg_dbg_i <= 1'b0;
    exp_mem.delete();
    all_erased = 1'b1;
    ld(16'h2002, 1'b0, 1'b0, ref_rd(16'h2002));
    stat(8'h01, 8'h00, "locked after mass erase");
    $display("test debugger done");
    reg_wr(2'h1, 8'h80);
    reset_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    reset_i <= 1'b0;
    ld(16'hfe40, 1'b0, 1'b0, ref_rd(16'hfe40));
    reg_rd(2'h1, d);
    chk(d, 8'h00, "page select after reset");
    $display("test second reset done");
    print_verdict();
  end
endmodule

`default_nettype wire
